/* rsm_top.sv */
// Receive slot mask, receive word capture and receive interrupt gating.
// Assumes an AHB-Lite master on hclk and serial pins from an external
// audio transmitter; the bit clock is oversampled, not used as a clock.
`timescale 1ns/1ns
module rsm_top
   import rsm_pkg::*;
#(
   parameter int SLOT_BITS   = 32,
   parameter int SLOTS       = 32,
   parameter int TIMEOUT_CYC = CLK_FAIL_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        rx_bit_clk,
   input  wire logic        rx_frame_sync,
   input  wire logic        rx_serial_data,
   input  wire logic        rx_dma_fault,
   output logic             rx_interrupt_line,
   output logic      [4:0]  rx_slot_index
);

   localparam int BW = (SLOT_BITS > 1) ? $clog2(SLOT_BITS) : 1;
   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [BW-1:0] BIT_LAST  = BW'(SLOT_BITS - 1);
   localparam logic [4:0]    SLOT_LAST = 5'(SLOTS - 1);
   localparam logic [CW-1:0] IDLE_LAST = CW'(TIMEOUT_CYC - 1);

   // Bus side
   logic                 hreadyout_q;
   logic                 hresp_q;
   logic [31:0]          hrdata_q;
   logic                 wr_pend_q;
   logic [7:0]           wr_addr_q;
   logic                 irq_q;

   // Registers
   logic [31:0]          slot_mask_q;
   logic [31:0]          slot_mask_d;
   logic [7:0]           irq_en_q;
   logic [7:0]           irq_en_d;
   logic [SLOT_BITS-1:0] rx_word_q;
   logic [SLOT_BITS-1:0] rx_word_d;
   logic                 word_full_q;
   logic                 word_full_d;
   logic [7:0]           pend_q;
   logic [7:0]           pend_d;

   // Serial side
   rsm_state_t           state_q;
   rsm_state_t           state_d;
   logic [BW-1:0]        bit_q;
   logic [BW-1:0]        bit_d;
   logic [4:0]           slot_q;
   logic [4:0]           slot_d;
   logic [SLOT_BITS-1:0] shift_q;
   logic [SLOT_BITS-1:0] shift_d;
   logic [CW-1:0]        idle_q;
   logic [CW-1:0]        idle_d;
   logic                 bclk_prev_q;
   logic [2:0]           pins_s;

   wire bclk_s = pins_s[2];
   wire fsync_s = pins_s[1];
   wire data_s = pins_s[0];

   // Address phase and data phase decode
   wire        bus_take = hsel & htrans[1] & hready;
   wire        rd_take  = bus_take & ~hwrite;
   wire [7:0]  rd_ofs   = haddr[7:0];
   wire        wr_mask  = wr_pend_q & (wr_addr_q == OFS_SLOT_MASK);
   wire        wr_ie    = wr_pend_q & (wr_addr_q == OFS_IRQ_EN);
   wire        wr_clr   = wr_pend_q & (wr_addr_q == OFS_PENDING);
   wire        rd_word  = rd_take & (rd_ofs == OFS_RX_WORD);
   wire [7:0]  clr_bits = wr_clr ? hwdata[7:0] : 8'h00;

   assign slot_mask_d = wr_mask ? hwdata : slot_mask_q;
   assign irq_en_d    = wr_ie ? (hwdata[7:0] & IRQ_EN_WMASK) : irq_en_q;

   // Mask, enable, pending and word reads use next values so a read right after a write sees the new data
   wire [31:0] status_word = {24'h00_0000, 1'b0, word_full_q, (state_q == ST_IN_FRAME),
                              slot_q};
   wire        rsel_mask  = (rd_ofs == OFS_SLOT_MASK);
   wire        rsel_ie    = (rd_ofs == OFS_IRQ_EN);
   wire        rsel_pend  = (rd_ofs == OFS_PENDING);
   wire        rsel_word  = (rd_ofs == OFS_RX_WORD);
   wire        rsel_state = (rd_ofs == OFS_RX_STATE);

   // Unmapped offsets fall through every select and read as zero
   wire [31:0] rd_value   = ({32{rsel_mask}}  & slot_mask_d)
                          | ({32{rsel_ie}}    & {24'h00_0000, irq_en_d})
                          | ({32{rsel_pend}}  & {24'h00_0000, pend_d})
                          | ({32{rsel_word}}  & 32'(rx_word_d))
                          | ({32{rsel_state}} & status_word);

   // Serial framing
   wire        bclk_rise  = bclk_s & ~bclk_prev_q;
   wire        in_frame   = (state_q == ST_IN_FRAME) | fsync_s;
   wire [4:0]  cur_slot   = fsync_s ? 5'h00 : slot_q;
   wire [BW-1:0] cur_bit  = fsync_s ? '0 : bit_q;
   wire        slot_on    = slot_mask_q[cur_slot];
   wire        shift_en   = bclk_rise & in_frame & slot_on;
   wire        last_bit   = (cur_bit == BIT_LAST);
   wire        last_slot  = (cur_slot == SLOT_LAST);
   wire        slot_done  = bclk_rise & in_frame & last_bit;
   wire        load_word  = slot_done & slot_on;
   wire        idle_out   = (state_q == ST_IN_FRAME) & ~bclk_rise & (idle_q == IDLE_LAST);

   // Events
   wire        ev_start   = bclk_rise & fsync_s;
   wire        ev_stray   = ev_start & (state_q == ST_IN_FRAME);
   wire        ev_final   = slot_done & last_slot;
   wire        ev_ovf     = load_word & word_full_q & ~rd_word;
   wire [7:0]  events;

   assign events[EV_FRAME_START] = ev_start;
   assign events[6]              = 1'b0;
   assign events[EV_DATA_READY]  = load_word;
   assign events[EV_FINAL_SLOT]  = ev_final;
   assign events[EV_DMA_FAULT]   = rx_dma_fault;
   assign events[EV_CLOCK_FAULT] = idle_out;
   assign events[EV_STRAY_SYNC]  = ev_stray;
   assign events[EV_OVERFLOW]    = ev_ovf;

   assign shift_d     = shift_en ? {shift_q[SLOT_BITS-2:0], data_s} : shift_q;
   assign rx_word_d   = load_word ? shift_d : rx_word_q;
   // A read in the load cycle already returns the new word, so it is consumed
   assign word_full_d = (load_word | word_full_q) & ~rd_word;

   // Slot and bit counters
   assign bit_d  = ~bclk_rise | ~in_frame ? bit_q :
                   last_bit ? '0 : cur_bit + BW'(1);
   assign slot_d = ~slot_done ? (ev_start ? 5'h00 : slot_q) :
                   last_slot ? 5'h00 : cur_slot + 5'h01;
   // Idle count runs only inside a frame: a quiet bit clock between frames is legal
   assign idle_d = (state_q != ST_IN_FRAME) | bclk_rise | idle_out ? '0 : idle_q + CW'(1);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_WAIT_SYNC:
         begin
            if (ev_start && !(slot_done && last_slot))
               state_d = ST_IN_FRAME;
         end
         ST_IN_FRAME:
         begin
            // A lost bit clock drops the frame; next sync restarts it
            if (idle_out || ev_final)
               state_d = ST_WAIT_SYNC;
         end
         default:
            state_d = ST_WAIT_SYNC;
      endcase
   end

   // Each lane resolves on its own, so data and sync must settle well before a clock rise
   rsm_sync #(
      .W (3)
   ) u_pin_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({rx_bit_clk, rx_frame_sync, rx_serial_data}),
      .sync_out (pins_s)
   );

   rsm_flags #(
      .W (EV_COUNT)
   ) u_pending (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .set_bits (events),
      .clr_bits (clr_bits),
      .flags_d  (pend_d),
      .flags_q  (pend_q)
   );

   // Bus slave: zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         hrdata_q    <= 32'h0000_0000;
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
      end
      else
      begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         wr_pend_q   <= bus_take & hwrite;
         if (bus_take)
            wr_addr_q <= haddr[7:0];
         if (rd_take)
            hrdata_q <= rd_value;
      end
   end

   // Software registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         slot_mask_q <= RST_SLOT_MASK;
         irq_en_q    <= RST_IRQ_EN;
      end
      else
      begin
         slot_mask_q <= slot_mask_d;
         irq_en_q    <= irq_en_d;
      end
   end

   // Each condition gated by its own enable; pending flags are untouched
   wire [7:0] gated = pend_q & irq_en_q;
   wire       irq_d = gated[EV_FRAME_START]
                    | gated[EV_DATA_READY]
                    | gated[EV_FINAL_SLOT]
                    | gated[EV_DMA_FAULT]
                    | gated[EV_CLOCK_FAULT]
                    | gated[EV_STRAY_SYNC]
                    | gated[EV_OVERFLOW];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   // Framing counters; edge detector resets to the idle level of the bit clock
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q     <= ST_WAIT_SYNC;
         bit_q       <= '0;
         slot_q      <= 5'h00;
         idle_q      <= '0;
         bclk_prev_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         bit_q       <= bit_d;
         slot_q      <= slot_d;
         idle_q      <= idle_d;
         bclk_prev_q <= bclk_s;
      end
   end

   // Word capture; the shift register holds still through inactive slots
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shift_q     <= '0;
         rx_word_q   <= RST_RX_WORD[SLOT_BITS-1:0];
         word_full_q <= 1'b0;
      end
      else
      begin
         shift_q     <= shift_d;
         rx_word_q   <= rx_word_d;
         word_full_q <= word_full_d;
      end
   end

   assign hreadyout         = hreadyout_q;
   assign hresp             = hresp_q;
   assign hrdata            = hrdata_q;
   assign rx_interrupt_line = irq_q;
   assign rx_slot_index     = slot_q;

endmodule

/* rsm_pkg.sv */
// Constants shared by the receive slot mask and interrupt enable block.
// Assumes a 100 MHz hclk and a word-wide AHB-Lite slave port.
//
// Contract
// - Slot mask is a 32-bit read/write register at 78h, reset all zero.
// - A slot whose mask bit is 0 shifts in no data bits.
// - A slot whose mask bit is 1 shifts in its data bits.
// - Interrupt asserts only for conditions whose enable bit is 1.
// - Enable bit 7 gates start of frame onto the interrupt.
// - Enable bit 5 gates data ready onto the interrupt.
// - Enable bit 4 gates last slot onto the interrupt.
// - Interrupt enable register at 7Ch resets with every enable bit zero.
// - Enable bits 31-8 and 6 read zero and ignore writes.
// - Enable bit 3 gates DMA error onto the interrupt.
// - Enable bit 2 gates clock failure onto the interrupt.
// - Enable bit 1 gates unexpected frame sync onto the interrupt.
// - Enable bit 0 gates overrun onto the interrupt.
package rsm_pkg;

   localparam logic [7:0]  OFS_SLOT_MASK  = 8'h78;
   localparam logic [7:0]  OFS_IRQ_EN     = 8'h7c;
   localparam logic [7:0]  OFS_PENDING    = 8'h90;
   localparam logic [7:0]  OFS_RX_WORD    = 8'h94;
   localparam logic [7:0]  OFS_RX_STATE   = 8'h98;

   localparam logic [31:0] RST_SLOT_MASK  = 32'h0000_0000;
   localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
   localparam logic [7:0]  RST_PENDING    = 8'h00;
   localparam logic [31:0] RST_RX_WORD    = 32'h0000_0000;

   // Writable enable bits; 6 stays reserved
   localparam logic [7:0]  IRQ_EN_WMASK   = 8'hbf;

   localparam int          EV_FRAME_START = 7;
   localparam int          EV_DATA_READY  = 5;
   localparam int          EV_FINAL_SLOT  = 4;
   localparam int          EV_DMA_FAULT   = 3;
   localparam int          EV_CLOCK_FAULT = 2;
   localparam int          EV_STRAY_SYNC  = 1;
   localparam int          EV_OVERFLOW    = 0;
   localparam int          EV_COUNT       = 8;

   localparam int          HCLK_PERIOD_NS = 10;
   localparam int          CLK_FAIL_NS    = 10000;
   localparam int          CLK_FAIL_CYC   = CLK_FAIL_NS / HCLK_PERIOD_NS;

   typedef enum logic [0:0]
   {
      ST_WAIT_SYNC = 1'b0,
      ST_IN_FRAME  = 1'b1
   } rsm_state_t;

endpackage

/* rsm_sync.sv */
// Two-flop synchroniser, one lane per bit.
// Assumes inputs come from pins outside the hclk domain.
`timescale 1ns/1ns
module rsm_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_lane
         logic meta_q;
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               meta_q      <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_q      <= async_in[i];
               sync_out[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule

/* rsm_flags.sv */
// Sticky pending flags: hardware sets, software clears by writing ones.
// Assumes set and clear are single-cycle terms on hclk.
`timescale 1ns/1ns
module rsm_flags #(
   parameter int W = 8
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   output logic      [W-1:0] flags_d,
   output logic      [W-1:0] flags_q
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_flag
         // Set wins over a clear in the same cycle so no event is lost
         assign flags_d[i] = set_bits[i] | (flags_q[i] & ~clr_bits[i]);
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               flags_q[i] <= 1'b0;
            else
               flags_q[i] <= flags_d[i];
         end
      end
   endgenerate

endmodule

/* rsm_assertions.sv */
// Checker on the ports of rsm_top, bound at the foot of this file.
// Assumes one hclk domain and a zero-wait bus slave.
`timescale 1ns/1ns
module rsm_assertions
   import rsm_pkg::*;
#(
   parameter int SLOTS = 32
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        rx_bit_clk,
   input wire logic        rx_frame_sync,
   input wire logic        rx_serial_data,
   input wire logic        rx_dma_fault,
   input wire logic        rx_interrupt_line,
   input wire logic [4:0]  rx_slot_index
);
   logic        wr_q;
   logic        rd_q;
   logic [7:0]  ofs_q;
   logic [31:0] mask_q;
   logic [7:0]  en_q;
   wire         take = hsel & htrans[1] & hready;
   // Shadow registers rebuilt from bus traffic, not read from the design
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         ofs_q  <= 8'h00;
         mask_q <= 32'h0000_0000;
         en_q   <= 8'h00;
      end
      else
      begin
         wr_q   <= take & hwrite;
         rd_q   <= take & ~hwrite;
         ofs_q  <= haddr[7:0];
         mask_q <= (wr_q && ofs_q == 8'h78) ? hwdata : mask_q;
         en_q   <= (wr_q && ofs_q == 8'h7c) ? (hwdata[7:0] & 8'hbf) : en_q;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_dma_evt;
      rx_dma_fault && en_q[3];
   endsequence
   sequence s_irq_up;
      ##[1:3] rx_interrupt_line;
   endsequence
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_irq_at_reset: assert property ($rose(hresetn) |-> !rx_interrupt_line)
      else $error("interrupt high after reset");
   a_mask_read: assert property (rd_q && ofs_q == 8'h78 |-> hrdata == mask_q)
      else $error("slot mask read wrong");
   a_enable_read: assert property (rd_q && ofs_q == 8'h7c |-> hrdata == {24'h0, en_q})
      else $error("interrupt enable read wrong");
   a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
      else $error("read data moved without a read");
   a_irq_needs_en: assert property (rx_interrupt_line |-> $past(en_q) != 8'h00)
      else $error("interrupt with no enable set");
   a_dma_irq: assert property (s_dma_evt |-> s_irq_up)
      else $error("enabled dma fault gave no interrupt");
   a_slot_range: assert property (rx_slot_index < SLOTS)
      else $error("slot index out of range");
endmodule

bind rsm_top rsm_assertions #(.SLOTS(SLOTS)) rsm_assertions_i (.*);

/* rsm_tx_model.sv */
// Behavioural audio transmitter on the receive pins, 8-bit slots.
// Assumes a bit clock far slower than hclk; it stands still between frames.
`timescale 1ns/1ns
module rsm_tx_model #(
   parameter int SLOT_BITS = 8,
   parameter int HALF_NS   = 40
) (
   output logic bclk,
   output logic fsync,
   output logic sdata
);
   initial
   begin
      bclk  = 1'b0;
      fsync = 1'b0;
      sdata = 1'b0;
   end
   // Slot s carries 8'ha0 + s; a second sync at bit resync, clock stops after nbits
   task automatic frame(input int nbits, input int resync);
      int         b;
      logic [7:0] w;
      for (int i = 0; i < nbits; i++)
      begin
         b = (resync > 0 && i >= resync) ? i - resync : i;
         w = 8'ha0 + 8'(b / SLOT_BITS);
         fsync = (b == 0);
         sdata = w[SLOT_BITS - 1 - b % SLOT_BITS];
         #HALF_NS bclk = 1'b1;
         #HALF_NS bclk = 1'b0;
      end
      fsync = 1'b0;
      // Released line must not keep the last bit
      sdata = ~sdata;
   endtask
endmodule

/* tb.sv */
// Self-checking bench for rsm_top with a serial transmitter model.
// Assumes a zero-wait slave; small slots and timeout keep the run short.
`timescale 1ns/1ns
module tb;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        bclk, fsync, sdata, rx_dma_fault, irq;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  slot_idx;
   int          n_errors = 0;
   int          n_compared = 0;

   rsm_tx_model rsm_tx_model_i (.bclk(bclk), .fsync(fsync), .sdata(sdata));
   rsm_top #(.SLOT_BITS(8), .SLOTS(4), .TIMEOUT_CYC(16)) rsm_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rx_bit_clk(bclk), .rx_frame_sync(fsync), .rx_serial_data(sdata),
      .rx_dma_fault(rx_dma_fault), .rx_interrupt_line(irq), .rx_slot_index(slot_idx)
   );

   task automatic finish_test;
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH time %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= a;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      check(q, e);
   endtask
   // Interrupt is registered two cycles after its cause
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge hclk);
      check({31'h0, irq}, {31'h0, e});
   endtask
   task automatic t_reset;
      rd(32'h0000_0078, 32'h0000_0000);
      rd(32'h0000_007c, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
   endtask
   task automatic t_regs;
      wr(32'h0000_0078, 32'ha5a5_5a5a);
      rd(32'h0000_0078, 32'ha5a5_5a5a);
      wr(32'h0000_007c, 32'hffff_ffff);
      rd(32'h0000_007c, 32'h0000_00bf);
      rd(32'h0000_0040, 32'h0000_0000);
      wr(32'h0000_007c, 32'h0000_0000);
   endtask
   // Slots 0 and 2 active: slot 2 overwrites slot 0 unread, slot 3 skipped
   task automatic t_mask;
      wr(32'h0000_0078, 32'h0000_0005);
      rsm_tx_model_i.frame(32, 0);
      repeat (8) @(posedge hclk);
      check({27'h000_0000, slot_idx}, 32'h0000_0000);
      rd(32'h0000_0098, 32'h0000_0040);
      rd(32'h0000_0094, 32'h0000_00a2);
      rd(32'h0000_0090, 32'h0000_00b1);
   endtask
   task automatic t_faults;
      wr(32'h0000_0078, 32'h0000_0000);
      wr(32'h0000_007c, 32'h0000_0008);
      rx_dma_fault <= 1'b1;
      @(posedge hclk);
      rx_dma_fault <= 1'b0;
      chk_irq(1'b1);
      rsm_tx_model_i.frame(12, 4);
      repeat (40) @(posedge hclk);
      // Resync restarted slot 0, which completed before the clock stopped
      check({27'h000_0000, slot_idx}, 32'h0000_0001);
      rd(32'h0000_0098, 32'h0000_0001);
      rd(32'h0000_0090, 32'h0000_00bf);
      rd(32'h0000_0094, 32'h0000_00a2);
   endtask
   task automatic t_gate;
      for (int b = 0; b < 8; b++)
      begin
         wr(32'h0000_007c, 32'h0000_0001 << b);
         chk_irq(b != 6);
      end
      wr(32'h0000_007c, 32'h0000_0000);
      chk_irq(1'b0);
      rd(32'h0000_0090, 32'h0000_00bf);
      wr(32'h0000_007c, 32'h0000_00bf);
      wr(32'h0000_0090, 32'h0000_00ff);
      chk_irq(1'b0);
   endtask

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      rx_dma_fault = 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_regs;
      t_mask;
      t_faults;
      t_gate;
      finish_test;
   end
   // Whole run is a few microseconds; this bound cuts a hang short
   initial
   begin
      #100000;
      n_errors++;
      finish_test;
   end
endmodule
